// File: rtl/fpc_pkg.sv
// constants for the flash protection command sequencer (host side)
// assumes an asynchronous x16 flash bus and an apb slave at 100 MHz
//
// How it works
// - exit any protection mode by writing 90 then 00 anywhere
// - lock register mode: AA/555, 55/2AA, 40/555; A0 then data; read
// - password mode: AA/555, 55/2AA, 60/555; A0 then word at its address
// - each program stores one 16-bit password portion; read offsets 00-03
// - unlock: 25, 03, four words at offsets 00-03, then 29
// - persistent mode entered with C0 at bank; A0 then 00 at block
// - guard-lock-bit mode entered by AA/555, 55/2AA, 50/555
// - in guard-lock-bit mode A0 then 00 clears the lock bit to zero
// - transient mode entered with E0; A0 then 00 protects, 01 unprotects
// - extended block mode via 88; A0 then address and data; single read
// - status and register fetches are bus reads; all else are writes
// - at least 1 us between successive password unlock commands
package fpc_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ADDR_OFS = 8'h04;
  localparam logic [7:0] DATA_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;
  localparam logic [7:0] RDAT_OFS = 8'h10;
  localparam logic [7:0] RST_OFS  = 8'h14;
  // command codes written to ctrl[3:0]
  typedef enum logic [3:0] {
    OP_ENTER_LOCKREG = 4'h0,
    OP_ENTER_PWD     = 4'h1,
    OP_ENTER_PERSIST = 4'h2,
    OP_ENTER_GLOCK   = 4'h3,
    OP_ENTER_TRANS   = 4'h4,
    OP_ENTER_EXT     = 4'h5,
    OP_EXIT          = 4'h6,
    OP_PROGRAM       = 4'h7,
    OP_CLEAR_ALL     = 4'h8,
    OP_READ1         = 4'h9,
    OP_PWD_READ      = 4'hA,
    OP_PWD_UNLOCK    = 4'hB
  } op_e;
  // flash address and data codes
  localparam logic [22:0] UNLK_A1 = 23'h00_0555;
  localparam logic [22:0] UNLK_A2 = 23'h00_02AA;
  localparam logic [15:0] UNLK_D1 = 16'h00AA;
  localparam logic [15:0] UNLK_D2 = 16'h0055;
  localparam logic [15:0] CD_LOCKREG = 16'h0040;
  localparam logic [15:0] CD_PWD     = 16'h0060;
  localparam logic [15:0] CD_PERSIST = 16'h00C0;
  localparam logic [15:0] CD_GLOCK   = 16'h0050;
  localparam logic [15:0] CD_TRANS   = 16'h00E0;
  localparam logic [15:0] CD_EXT     = 16'h0088;
  localparam logic [15:0] CD_PROG    = 16'h00A0;
  localparam logic [15:0] CD_EXIT1   = 16'h0090;
  localparam logic [15:0] CD_ZERO    = 16'h0000;
  localparam logic [15:0] CD_CLR1    = 16'h0080;
  localparam logic [15:0] CD_CLR2    = 16'h0030;
  localparam logic [15:0] CD_UNL1    = 16'h0025;
  localparam logic [15:0] CD_UNL2    = 16'h0003;
  localparam logic [15:0] CD_UNL3    = 16'h0029;
  localparam logic [22:0] ADR_ZERO   = 23'h00_0000;
  // bus cycle timing, in pclk cycles per phase
  localparam int unsigned PHASE_CYC = 4;
  // spacing between password unlock commands
  localparam int unsigned UNLOCK_GAP_NS = 1000;
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned UNLOCK_GAP_CYC =
    (UNLOCK_GAP_NS + CLK_NS - 1) / CLK_NS;
endpackage : fpc_pkg

// File: rtl/fpc_host.sv
// host sequencer that issues flash protection command sets on flash pins
// assumes an async x16 flash; apb slave with zero wait states
`timescale 1ns/1ps
module fpc_host
  import fpc_pkg::*;
(
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // flash bus
  output logic      [22:0] fl_addr,
  input  wire logic [15:0] fl_dq_in,
  output logic      [15:0] fl_dq_out,
  output logic             fl_dq_oe,
  output logic             fl_ce_n,
  output logic             fl_oe_n,
  output logic             fl_we_n,
  output logic             fl_rst_n
);
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_SETUP = 3'b001,
    S_STRB  = 3'b010,
    S_HOLD  = 3'b011,
    S_NEXT  = 3'b100
  } st_e;

  st_e          st_q;
  logic [3:0]   op_q;
  logic [2:0]   idx_q;
  logic [2:0]   len_q;
  logic [2:0]   cnt_q;
  logic [22:0]  arg_addr_q;
  logic [63:0]  arg_data_q;
  logic [63:0]  rdat_q;
  logic         busy_q;
  logic         rst_req_q;
  logic [7:0]   rst_cnt_q;
  logic [15:0]  gap_q;
  logic         gap_wait_q;
  logic [15:0]  dq_s1_q;
  logic [15:0]  dq_s2_q;
  logic         wr_en;
  logic         rd_en;
  logic         cyc_rd;
  logic [22:0]  cyc_addr;
  logic [15:0]  cyc_data;

  // step table: length of each command, in bus cycles
  function automatic logic [2:0] op_len(input logic [3:0] op);
    unique case (op)
      OP_ENTER_LOCKREG, OP_ENTER_PWD, OP_ENTER_PERSIST,
      OP_ENTER_GLOCK, OP_ENTER_TRANS, OP_ENTER_EXT: op_len = 3'd3;
      OP_EXIT, OP_PROGRAM, OP_CLEAR_ALL: op_len = 3'd2;
      OP_READ1: op_len = 3'd1;
      OP_PWD_READ: op_len = 3'd4;
      OP_PWD_UNLOCK: op_len = 3'd7;
      default: op_len = 3'd0;
    endcase
  endfunction : op_len

  function automatic logic [15:0] enter_code(input logic [3:0] op);
    unique case (op)
      OP_ENTER_LOCKREG: enter_code = CD_LOCKREG;
      OP_ENTER_PWD:     enter_code = CD_PWD;
      OP_ENTER_PERSIST: enter_code = CD_PERSIST;
      OP_ENTER_GLOCK:   enter_code = CD_GLOCK;
      OP_ENTER_TRANS:   enter_code = CD_TRANS;
      default:          enter_code = CD_EXT;
    endcase
  endfunction : enter_code

  // the word of the current step: address, data and direction
  always_comb
  begin
    cyc_rd   = 1'b0;
    cyc_addr = arg_addr_q;
    cyc_data = CD_ZERO;
    unique case (op_q)
      OP_EXIT:
        cyc_data = (idx_q == 3'd0) ? CD_EXIT1 : CD_ZERO;
      OP_PROGRAM:
        cyc_data = (idx_q == 3'd0) ? CD_PROG : arg_data_q[15:0];
      OP_CLEAR_ALL:
      begin
        cyc_addr = ADR_ZERO;
        cyc_data = (idx_q == 3'd0) ? CD_CLR1 : CD_CLR2;
      end
      OP_READ1:
        cyc_rd = 1'b1;
      OP_PWD_READ:
      begin
        cyc_rd   = 1'b1;
        cyc_addr = {20'h0_0000, idx_q};
      end
      OP_PWD_UNLOCK:
      begin
        // offsets 00,00,00,01,02,03,00 carry 25,03,words,29
        cyc_addr = (idx_q >= 3'd2 && idx_q <= 3'd5) ?
                   {20'h0_0000, idx_q - 3'd2} : ADR_ZERO;
        if (idx_q == 3'd0)
          cyc_data = CD_UNL1;
        else if (idx_q == 3'd1)
          cyc_data = CD_UNL2;
        else if (idx_q == 3'd6)
          cyc_data = CD_UNL3;
        else
          cyc_data = arg_data_q[16*(idx_q-3'd2) +: 16];
      end
      default:
      begin
        // three-cycle entry: 555/AA, 2AA/55, bank|555/code
        if (idx_q == 3'd0)
        begin
          cyc_addr = UNLK_A1;
          cyc_data = UNLK_D1;
        end
        else if (idx_q == 3'd1)
        begin
          cyc_addr = UNLK_A2;
          cyc_data = UNLK_D2;
        end
        else
        begin
          cyc_addr = arg_addr_q | UNLK_A1;        // bank bits kept
          cyc_data = enter_code(op_q);
        end
      end
    endcase
  end

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // apb register writes and command launch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_q       <= 4'h0;
      arg_addr_q <= 23'h00_0000;
      arg_data_q <= 64'h0000_0000_0000_0000;
      busy_q     <= 1'b0;
      rst_req_q  <= 1'b0;
    end
    else
    begin
      rst_req_q <= 1'b0;
      if (wr_en && paddr == ADDR_OFS)
        arg_addr_q <= pwdata[22:0];
      if (wr_en && paddr == DATA_OFS)
        arg_data_q <= {arg_data_q[31:0], pwdata};
      if (wr_en && paddr == RST_OFS)
        rst_req_q <= 1'b1;
      if (wr_en && paddr == CTRL_OFS && !busy_q
          && op_len(pwdata[3:0]) != 3'd0)
      begin
        op_q   <= pwdata[3:0];
        busy_q <= 1'b1;
      end
      else if (st_q == S_NEXT && idx_q + 3'd1 == len_q)
        busy_q <= 1'b0;
    end
  end

  // apb read side: one cycle answer, zero wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_en)
      unique case (paddr)
        CTRL_OFS: prdata <= {28'h000_0000, op_q};
        ADDR_OFS: prdata <= {9'h000, arg_addr_q};
        DATA_OFS: prdata <= arg_data_q[31:0];
        STAT_OFS: prdata <= {30'h0000_0000, gap_wait_q, busy_q};
        RDAT_OFS: prdata <= rdat_q[31:0];
        RST_OFS:  prdata <= rdat_q[63:32];
        default:  prdata <= 32'h0000_0000;
      endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && paddr > RST_OFS;
    end
  end

  // two-flop sync of the data pins before capture
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
    end
    else
    begin
      dq_s1_q <= fl_dq_in;
      dq_s2_q <= dq_s1_q;
    end
  end

  // bus cycle sequencer: setup, strobe, hold per step
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q  <= S_IDLE;
      idx_q <= 3'd0;
      cnt_q <= 3'd0;
      len_q <= 3'd0;
    end
    else
      unique case (st_q)
        S_IDLE:
          if (busy_q && !(op_q == OP_PWD_UNLOCK && gap_wait_q))
          begin
            st_q  <= S_SETUP;
            idx_q <= 3'd0;
            len_q <= op_len(op_q);
            cnt_q <= 3'd0;
          end
        S_SETUP, S_STRB, S_HOLD:
          if (cnt_q == 3'(PHASE_CYC - 1))
          begin
            cnt_q <= 3'd0;
            st_q  <= (st_q == S_SETUP) ? S_STRB :
                     (st_q == S_STRB) ? S_HOLD : S_NEXT;
          end
          else
            cnt_q <= cnt_q + 3'd1;
        S_NEXT:
          if (idx_q + 3'd1 == len_q)
            st_q <= S_IDLE;
          else
          begin
            idx_q <= idx_q + 3'd1;
            st_q  <= S_SETUP;
          end
      endcase
  end

  // capture read words; the synced data is sampled at strobe end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdat_q <= 64'h0000_0000_0000_0000;
    else if (st_q == S_HOLD && cnt_q == 3'd0 && cyc_rd)
      rdat_q[16*idx_q[1:0] +: 16] <= dq_s2_q;
  end

  // unlock spacing timer, restarted by each unlock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gap_q      <= 16'h0000;
      gap_wait_q <= 1'b0;
    end
    else if (st_q == S_NEXT && op_q == OP_PWD_UNLOCK
             && idx_q + 3'd1 == len_q)
    begin
      gap_q      <= 16'(UNLOCK_GAP_CYC);
      gap_wait_q <= 1'b1;
    end
    else if (gap_q != 16'h0000)
      gap_q <= gap_q - 16'h0001;
    else
      gap_wait_q <= 1'b0;
  end

  // flash pins, all from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fl_addr   <= 23'h00_0000;
      fl_dq_out <= 16'h0000;
      fl_dq_oe  <= 1'b0;
      fl_ce_n   <= 1'b1;
      fl_oe_n   <= 1'b1;
      fl_we_n   <= 1'b1;
      fl_rst_n  <= 1'b0;
    end
    else
    begin
      fl_rst_n  <= !rst_req_q;
      fl_addr   <= cyc_addr;
      fl_dq_out <= cyc_data;
      fl_dq_oe  <= (st_q != S_IDLE) && !cyc_rd;
      fl_ce_n   <= !(st_q == S_SETUP || st_q == S_STRB || st_q == S_HOLD);
      fl_we_n   <= !(st_q == S_STRB && !cyc_rd);
      fl_oe_n   <= !((st_q == S_STRB || st_q == S_HOLD) && cyc_rd);
    end
  end

  // a_ assertions
  a_we_oe_excl : assert property (@(posedge pclk) disable iff (!presetn)
    !(!fl_we_n && !fl_oe_n))
    else $error("write and output enable both low");
  a_we_hold : assert property (@(posedge pclk) disable iff (!presetn)
    $fell(fl_we_n) |-> !fl_we_n [*4] ##1 fl_we_n)
    else $error("write strobe width wrong");
  a_unlock_gap : assert property (@(posedge pclk) disable iff (!presetn)
    $rose(gap_wait_q) |-> !(st_q == S_SETUP && op_q == OP_PWD_UNLOCK)
    [*8])
    else $error("unlock issued inside gap");
  a_unlock_space : assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == S_IDLE && op_q == OP_PWD_UNLOCK && gap_q != 16'h0000)
    |=> st_q == S_IDLE)
    else $error("unlock started before spacing ran out");
  a_rd_no_drive : assert property (@(posedge pclk) disable iff (!presetn)
    !fl_oe_n |-> !fl_dq_oe)
    else $error("pins driven during read");
  a_pready_one : assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("apb answer late");
  a_rst_pulse : assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == RST_OFS) |-> ##2 !fl_rst_n)
    else $error("reset pin not pulsed");
  a_exit_code : assert property (@(posedge pclk) disable iff (!presetn)
    (op_q == OP_EXIT && st_q == S_STRB && idx_q == 3'd0)
    |=> fl_dq_out == CD_EXIT1)
    else $error("exit code wrong");
  a_unlock_tail : assert property (@(posedge pclk) disable iff (!presetn)
    (op_q == OP_PWD_UNLOCK && st_q == S_STRB && idx_q == 3'd6)
    |=> fl_dq_out == CD_UNL3 && fl_addr == ADR_ZERO)
    else $error("unlock tail wrong");
endmodule : fpc_host

// File: tb/flash_model.sv
// flash device model: protection command sets on an async x16 bus
// assumes the host strobes we/oe low while ce is low, one word per strobe
`timescale 1ns/1ps
module flash_model (
  // flash pins
  input  wire logic [22:0] fl_addr,
  input  wire logic [15:0] fl_dq_out,
  input  wire logic        fl_dq_oe,
  input  wire logic        fl_ce_n,
  input  wire logic        fl_oe_n,
  input  wire logic        fl_we_n,
  input  wire logic        fl_rst_n,
  output logic      [15:0] fl_dq_in
);
  logic [7:0]  mode_q;
  logic [1:0]  seq_q;
  logic        pend_q, ex_q, clr_q;
  logic        lock_q = 1'b1;
  logic [15:0] lreg_q = 16'hFFFF;
  logic [15:0] pw_q [4];
  // block number from the upper address bits; plain default width
  localparam int BLK_LSB = 16;
  logic        pb_q [int];
  logic        vb_q [int];
  logic [15:0] ext_q [int];
  logic        pbit, vbit;
  int          rblk, wblk;
  logic [15:0] rd;
  logic [22:0] wa_q [$];
  logic [15:0] wd_q [$];
  realtime     wt_q [$];
  int          errs = 0;
  int          resets = 0;
  // command decode on the rising write strobe; only the low byte
  // and the low address bits take part in the codes
  always @(posedge fl_we_n or negedge fl_rst_n)
    if (!fl_rst_n)
    begin
      mode_q = 8'h00;
      {seq_q, pend_q, ex_q, clr_q} = '0;
      vb_q.delete(); // transient bits are volatile
      resets++;
    end
    else if (!fl_ce_n)
    begin
      wa_q.push_back(fl_addr);
      wd_q.push_back(fl_dq_out);
      wt_q.push_back($realtime);
      if (!fl_dq_oe)
        errs++;
      if (pend_q)
      begin
        pend_q = 1'b0;
        wblk = int'(fl_addr[22:BLK_LSB]);
        case (mode_q)
          8'h40: lreg_q = fl_dq_out;
          8'h60: pw_q[fl_addr[1:0]] = fl_dq_out;
          // block 0 is shut, and a cleared lock bit freezes
          8'hC0: if (wblk != 0 && lock_q) pb_q[wblk] = fl_dq_out[0];
          8'hE0: if (wblk != 0) vb_q[wblk] = fl_dq_out[0];
          8'h88: ext_q[fl_addr] = fl_dq_out;
          8'h50: lock_q = fl_dq_out[0];
          default: ;
        endcase
      end
      else if (mode_q != 8'h00 && fl_dq_out[7:0] == 8'hA0)
        pend_q = 1'b1;
      else if (mode_q != 8'h00 && fl_dq_out[7:0] == 8'h90)
        ex_q = 1'b1;
      else if (ex_q && fl_dq_out[7:0] == 8'h00)
        {mode_q, ex_q} = '0;
      else if (mode_q == 8'hC0 && fl_dq_out[7:0] == 8'h80)
        clr_q = 1'b1;
      else if (clr_q && fl_dq_out[7:0] == 8'h30)
      begin
        clr_q = 1'b0;
        if (lock_q)
          pb_q.delete();
      end
      else if (fl_dq_out[7:0] == 8'hAA && fl_addr[10:0] == 11'h555)
        seq_q = 2'd1;
      else if (seq_q == 2'd1 && fl_addr[10:0] == 11'h2AA)
        seq_q = 2'd2;
      else if (seq_q == 2'd2 && fl_addr[10:0] == 11'h555)
        {mode_q, seq_q} = {fl_dq_out[7:0], 2'd0};
      else
        {seq_q, ex_q, clr_q} = '0;
    end
  // a read must never meet a driven data bus
  always @(negedge fl_oe_n)
    if (!fl_ce_n && fl_dq_oe)
      errs++;
  // read value by mode; the released bus shows the inverse
  // listed on the pins, since stored bits only change while oe is high
  always @(fl_addr or fl_ce_n or fl_oe_n or mode_q)
  begin
    rblk = int'(fl_addr[22:BLK_LSB]);
    pbit = pb_q.exists(rblk) ? pb_q[rblk] : 1'b1;
    vbit = vb_q.exists(rblk) ? vb_q[rblk] : 1'b1;
    case (mode_q)
      8'h40: rd = lreg_q;
      8'h60: rd = pw_q[fl_addr[1:0]];
      8'hC0: rd = {15'h0, pbit};
      8'hE0: rd = {15'h0, pbit & vbit};
      8'h50: rd = {15'h0, lock_q};
      8'h88: rd = ext_q.exists(fl_addr) ? ext_q[fl_addr] : 16'hFFFF;
      default: rd = 16'hFFFF;
    endcase
    if ((mode_q == 8'hC0 || mode_q == 8'hE0) && rblk == 0)
      rd = 16'hFFFF;
    fl_dq_in = (!fl_ce_n && !fl_oe_n) ? rd : ~rd;
  end
endmodule : flash_model

// File: tb/tb_top.sv
// self-checking bench for the flash protection host sequencer
// assumes fpc_pkg and flash_model; apb master at 100 MHz
`timescale 1ns/1ps
module tb_top;
  import fpc_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err;
  logic [22:0] fl_addr;
  logic [15:0] fl_dq_in, fl_dq_out;
  logic        fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_rst_n;
  int          fails = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          nrst;
  logic [15:0] cd [6] = '{16'h0040, 16'h0060, 16'h00C0, 16'h0050,
                          16'h00E0, 16'h0088};
  logic [15:0] pw [4] = '{16'h1357, 16'h2468, 16'h3579, 16'h4681};
  fpc_host i_fpc_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fl_addr(fl_addr), .fl_dq_in(fl_dq_in), .fl_dq_out(fl_dq_out),
    .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n), .fl_rst_n(fl_rst_n));
  flash_model i_flash_model (.fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
    .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n), .fl_rst_n(fl_rst_n), .fl_dq_in(fl_dq_in));
  // clock and a hang guard well above the expected run length
  always #5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      fails++;
      $display("ERROR %0t timeout", $time);
      stop_test();
    end
  end
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // next flash write cycle seen by the model
  task automatic ew(input logic [22:0] a, input logic [15:0] d);
    logic [39:0] g;
    g = 40'hFF_FFFF_FFFF;
    if (i_flash_model.wa_q.size() > 0)
      g = {1'b0, i_flash_model.wa_q.pop_front(),
           i_flash_model.wd_q.pop_front()};
    chk(g, {1'b0, a, d});
  endtask : ew
  task automatic flush;
    i_flash_model.wa_q.delete();
    i_flash_model.wd_q.delete();
    i_flash_model.wt_q.delete();
  endtask : flush
  // start an op and poll busy; the bench timeout bounds the wait
  task automatic op(input op_e c, input logic [22:0] a,
                    input logic [31:0] d);
    apb(1'b1, ADDR_OFS, {9'h000, a});
    apb(1'b1, DATA_OFS, d);
    apb(1'b1, CTRL_OFS, {28'h000_0000, c});
    rd = 32'h0000_0001;
    while (rd[0] !== 1'b0)
      apb(1'b0, STAT_OFS, 32'h0000_0000);
  endtask : op
  task automatic enter(input op_e c);
    op(c, 23'h00_0000, 32'h0000_0000);
    flush();
  endtask : enter
  task automatic rdat(input logic [22:0] a, input logic [15:0] e);
    op(OP_READ1, a, 32'h0000_0000);
    apb(1'b0, RDAT_OFS, 32'h0000_0000);
    chk(rd[15:0], e);
  endtask : rdat
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({fl_ce_n, fl_we_n, fl_oe_n, fl_rst_n, fl_dq_oe}, 40'h1E);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk({err, rd}, 40'h01_0000_0000);
    $display("test reset done");
    // every entry sequence followed by the exit pair
    for (int i = 0; i < 6; i++)
    begin
      op(op_e'(i), 23'h00_0000, 32'h0000_0000);
      ew(23'h0555, 16'h00AA);
      ew(23'h02AA, 16'h0055);
      ew(23'h0555, cd[i]);
      op(OP_EXIT, 23'h00_0000, 32'h0000_0000);
      ew(23'h0000, 16'h0090);
      ew(23'h0000, 16'h0000);
      chk(i_flash_model.mode_q, 40'h0);
    end
    $display("test entry done");
    enter(OP_ENTER_LOCKREG);
    op(OP_PROGRAM, 23'h00_0000, 32'h0000_1234);
    ew(23'h0000, 16'h00A0);
    ew(23'h0000, 16'h1234);
    rdat(23'h00_0000, 16'h1234);
    op(OP_EXIT, 23'h00_0000, 32'h0000_0000);
    $display("test lock register done");
    // password words programmed out of order, read back, unlocked twice
    enter(OP_ENTER_PWD);
    for (int n = 3; n >= 0; n--)
    begin
      op(OP_PROGRAM, 23'(n), {16'h0000, pw[n]});
      ew(23'(n), 16'h00A0);
      ew(23'(n), pw[n]);
    end
    op(OP_PWD_READ, 23'h00_0000, 32'h0000_0000);
    apb(1'b0, RDAT_OFS, 32'h0000_0000);
    chk(rd, {pw[1], pw[0]});
    apb(1'b0, RST_OFS, 32'h0000_0000);
    chk(rd, {pw[3], pw[2]});
    flush();
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b1, DATA_OFS, {pw[3], pw[2]});
      op(OP_PWD_UNLOCK, 23'h00_0000, {pw[1], pw[0]});
    end
    ew(23'h0000, 16'h0025);
    ew(23'h0000, 16'h0003);
    for (int n = 0; n < 4; n++)
      ew(23'(n), pw[n]);
    ew(23'h0000, 16'h0029);
    chk(i_flash_model.wt_q[7] - i_flash_model.wt_q[6] >= 1000.0, 1);
    op(OP_EXIT, 23'h00_0000, 32'h0000_0000);
    $display("test password done");
    enter(OP_ENTER_PERSIST);
    op(OP_PROGRAM, 23'h04_0000, 32'h0000_0000);
    ew(23'h04_0000, 16'h00A0);
    ew(23'h04_0000, 16'h0000);
    rdat(23'h04_0000, 16'h0000);
    op(OP_CLEAR_ALL, 23'h00_0000, 32'h0000_0000);
    ew(23'h0000, 16'h0080);
    ew(23'h0000, 16'h0030);
    rdat(23'h04_0000, 16'h0001);
    op(OP_PROGRAM, 23'h05_0000, 32'h0000_0000);
    rdat(23'h05_0000, 16'h0000);
    op(OP_PROGRAM, 23'h00_0000, 32'h0000_0000);
    rdat(23'h00_0000, 16'hFFFF);
    op(OP_EXIT, 23'h00_0000, 32'h0000_0000);
    enter(OP_ENTER_GLOCK);
    op(OP_PROGRAM, 23'h00_0000, 32'h0000_0000);
    ew(23'h0000, 16'h00A0);
    ew(23'h0000, 16'h0000);
    rdat(23'h00_0000, 16'h0000);
    op(OP_EXIT, 23'h00_0000, 32'h0000_0000);
    // lock bit now zero: clear-all must fail and block 5 stays set
    enter(OP_ENTER_PERSIST);
    op(OP_CLEAR_ALL, 23'h00_0000, 32'h0000_0000);
    rdat(23'h05_0000, 16'h0000);
    op(OP_EXIT, 23'h00_0000, 32'h0000_0000);
    enter(OP_ENTER_TRANS);
    op(OP_PROGRAM, 23'h05_0000, 32'h0000_0001);
    ew(23'h05_0000, 16'h00A0);
    ew(23'h05_0000, 16'h0001);
    rdat(23'h05_0000, 16'h0000);
    op(OP_PROGRAM, 23'h06_0000, 32'h0000_0000);
    rdat(23'h06_0000, 16'h0000);
    op(OP_PROGRAM, 23'h06_0000, 32'h0000_0001);
    rdat(23'h06_0000, 16'h0001);
    op(OP_EXIT, 23'h00_0000, 32'h0000_0000);
    enter(OP_ENTER_EXT);
    op(OP_PROGRAM, 23'h00_0010, 32'h0000_5A3C);
    ew(23'h00_0010, 16'h00A0);
    ew(23'h00_0010, 16'h5A3C);
    rdat(23'h00_0010, 16'h5A3C);
    op(OP_EXIT, 23'h00_0000, 32'h0000_0000);
    $display("test protection bits done");
    // reset pulse drops the device out of a mode
    enter(OP_ENTER_LOCKREG);
    nrst = i_flash_model.resets;
    apb(1'b1, RST_OFS, 32'h0000_0000);
    repeat (4) @(posedge pclk);
    chk(i_flash_model.resets, nrst + 1);
    chk(i_flash_model.mode_q, 40'h0);
    chk(i_flash_model.errs, 40'h0);
    $display("test reset pulse done");
    stop_test();
  end
endmodule : tb_top
